// file: design/pia_interrupt_arbiter_unit.sv
// Interrupt arbiter unit with request nodes, CPU entry sequencing and an AHB-Lite slave.
`timescale 1ns/1ps
// How it works
// - A newly raised node request starts an arbitration round automatically.
// - Round end stores the largest competing priority number as pending priority.
// - CPU request asserted only while pending priority exceeds current priority.
// - Accepted interrupt runs an acknowledge cycle; the winning node clears pending.
// - Only a folded return is taken while the global enable is zero.
// - Only a folded return is taken while current priority is 0xFF.
// - Acceptance waits while entry, return, traps, power, multicycle or control hold.
// - With current priority not below pending, the unit idles until change.
// - A new request first clears pending priority to zero, then rearbitrates.
// - Current priority changes by write or return re-evaluate the pending request.
// - Arbitration runs regardless of global enable or CPU hold conditions.
// - Return with higher pending priority branches straight to the new handler.
// - Entry saves context, clears enable, copies priority, loads status, fetches.
// - Default status enables permissions, interrupt map, interrupt stack, depth 64.
// - Handler address is current priority shifted left five, ORed with base.
// - Vector entries are eight words apart, one per priority, up to 256.
// - Vector base resets fixed and is writable only before interrupts are enabled.
// - Software may write current priority to any value to mask groups.
// - A node with priority number zero never competes.
// - Node word holds pending bit 10, enable bit 9, type bit 8, priority 7:0.
// - Control word holds current priority, enable, pending priority, cycle select.
module pia_interrupt_arbiter_unit #(
  parameter int NODES = pia_pkg::NODE_COUNT
) (
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic      [31:0]                   hrdata,
  input  wire logic [NODES-1:0]              hwRequest,
  input  wire logic [pia_pkg::HOLD_W-1:0]    cpuHoldOff,
  input  wire logic                          returnStrobe,
  input  wire logic [7:0]                    returnPriority,
  output logic                               intRequest,
  output logic                               cpuAccept,
  output logic                               ackStrobe,
  output logic      [$clog2(NODES)-1:0]      ackNode,
  output logic                               foldBranch,
  output logic                               ctxSave,
  output logic                               statusLoad,
  output logic      [31:0]                   statusWord,
  output logic                               fetchStrobe,
  output logic      [31:0]                   vectorAddr,
  output logic      [7:0]                    curPriority,
  output logic      [7:0]                    pendPriority,
  output logic                               globalEnable
);
  import pia_pkg::*;

  localparam int IDXW = $clog2(NODES);

  function automatic logic isNode(input logic [11:0] addr, input int k);
    isNode = addr == NODE_OFFSET + 12'(4 * k);
  endfunction : isNode

  pia_state_t       stateReg,    stateNext;
  logic [1:0]       cntReg,      cntNext;
  logic [7:0]       curPrioReg,  curPrioNext;
  logic [7:0]       pendPrioReg, pendPrioNext;
  logic             enableReg,   enableNext;
  logic [1:0]       arbSelReg,   arbSelNext;
  logic [31:0]      vecBaseReg,  vecBaseNext;
  logic             baseLockReg, baseLockNext;
  logic [IDXW-1:0]  winIdxReg,   winIdxNext;
  logic             foldReg,     foldNext;
  logic [31:0]      vecAddrReg,  vecAddrNext;
  logic [31:0]      statusReg,   statusNext;
  logic [NODES-1:0] pendReg,     pendNext;
  logic [NODES-1:0] enReg,       enNext;
  logic [NODES-1:0] typeReg,     typeNext;
  logic [7:0]       prioReg      [NODES];
  logic [7:0]       prioNext     [NODES];
  logic [11:0]      addrReg,     addrNext;
  logic             wrPendReg,   wrPendNext;
  logic             rdPendReg,   rdPendNext;
  logic             rdDoneReg,   rdDoneNext;
  logic [31:0]      rdataReg,    rdataNext;
  logic [31:0]      rdWord;
  logic [31:0]      icwWord;
  logic [NODES-1:0] newEvent;
  logic             newReq;
  logic             takeOk;
  logic             icwWrite;
  logic [7:0]       winPrio;
  logic [IDXW-1:0]  winIdx;

  pia_winner_select #(
    .NODES   (NODES),
    .IDXW    (IDXW)
  ) u_winner (
    .pend    (pendReg),
    .enable  (enReg),
    .svcType (typeReg),
    .prio    (prioReg),
    .winPrio (winPrio),
    .winIdx  (winIdx)
  );

  // Bus slave: writes complete with no wait, reads insert one wait state.
  assign hreadyout = !(rdPendReg && !rdDoneReg);
  assign hresp     = 1'b0;
  assign hrdata    = rdataReg;
  assign icwWord   = {6'h00, arbSelReg, pendPrioReg, 7'h00, enableReg, curPrioReg};
  assign icwWrite  = wrPendReg && addrReg == ICW_OFFSET;

  always_comb begin
    rdWord = 32'h0000_0000;
    if (addrReg == ICW_OFFSET) begin
      rdWord = icwWord;
    end else if (addrReg == VBR_OFFSET) begin
      rdWord = vecBaseReg;
    end
    for (int k = 0; k < NODES; k++) begin
      if (isNode(addrReg, k)) begin
        rdWord = {21'h000000, pendReg[k], enReg[k], typeReg[k], prioReg[k]};
      end
    end
  end

  always_comb begin
    addrNext   = addrReg;
    wrPendNext = 1'b0;
    rdPendNext = rdPendReg;
    rdDoneNext = rdDoneReg;
    rdataNext  = rdataReg;
    if (rdPendReg && !rdDoneReg) begin
      rdataNext  = rdWord;
      rdDoneNext = 1'b1;
    end else if (rdPendReg) begin
      rdPendNext = 1'b0;
      rdDoneNext = 1'b0;
    end
    if (hsel && htrans[1] && hready) begin
      addrNext   = {haddr[11:2], 2'b00};
      wrPendNext = hwrite;
      rdPendNext = !hwrite;
      rdDoneNext = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      addrReg   <= 12'h000;
      wrPendReg <= 1'b0;
      rdPendReg <= 1'b0;
      rdDoneReg <= 1'b0;
      rdataReg  <= 32'h0000_0000;
    end else begin
      addrReg   <= addrNext;
      wrPendReg <= wrPendNext;
      rdPendReg <= rdPendNext;
      rdDoneReg <= rdDoneNext;
      rdataReg  <= rdataNext;
    end
  end

  // Request nodes: a hardware set beats a software or acknowledge clear.
  always_comb begin
    for (int k = 0; k < NODES; k++) begin
      pendNext[k] = pendReg[k];
      enNext[k]   = enReg[k];
      typeNext[k] = typeReg[k];
      prioNext[k] = prioReg[k];
      if (stateReg == ST_ACK && winIdxReg == IDXW'(k)) begin
        pendNext[k] = 1'b0;
      end
      if (wrPendReg && isNode(addrReg, k)) begin
        pendNext[k] = hwdata[NODE_PEND_POS];
        enNext[k]   = hwdata[NODE_EN_POS];
        typeNext[k] = hwdata[NODE_TYPE_POS];
        prioNext[k] = hwdata[NODE_PRIO_POS +: 8];
      end
      if (hwRequest[k]) begin
        pendNext[k] = 1'b1;
      end
      newEvent[k] = pendNext[k] && !pendReg[k];
    end
  end

  assign newReq = |newEvent;

  always_ff @(posedge clock) begin
    if (rst) begin
      pendReg <= '0;
      enReg   <= '0;
      typeReg <= '0;
      for (int k = 0; k < NODES; k++) begin
        prioReg[k] <= PRIO_NONE;
      end
    end else begin
      pendReg <= pendNext;
      enReg   <= enNext;
      typeReg <= typeNext;
      for (int k = 0; k < NODES; k++) begin
        prioReg[k] <= prioNext[k];
      end
    end
  end

  // Arbitration and CPU entry sequencing.
  assign intRequest = pendPrioReg > curPrioReg;
  assign takeOk     = enableReg && curPrioReg != PRIO_MAX
                      && cpuHoldOff == '0 && !returnStrobe;
  assign cpuAccept  = stateReg == ST_IDLE && !newReq && intRequest && takeOk;
  assign ackStrobe  = stateReg == ST_ACK;
  assign ackNode    = winIdxReg;
  assign foldBranch = stateReg == ST_ACK && foldReg;
  assign ctxSave    = stateReg == ST_SAVE;
  assign statusLoad = stateReg == ST_STATUS;
  assign fetchStrobe = stateReg == ST_FETCH;
  assign statusWord = statusReg;
  assign vectorAddr = vecAddrReg;
  assign curPriority  = curPrioReg;
  assign pendPriority = pendPrioReg;
  assign globalEnable = enableReg;

  always_comb begin
    stateNext    = stateReg;
    cntNext      = cntReg;
    curPrioNext  = curPrioReg;
    pendPrioNext = pendPrioReg;
    enableNext   = enableReg;
    arbSelNext   = arbSelReg;
    vecBaseNext  = vecBaseReg;
    baseLockNext = baseLockReg | enableReg;
    winIdxNext   = winIdxReg;
    foldNext     = foldReg;
    vecAddrNext  = vecAddrReg;
    statusNext   = statusReg;
    if (icwWrite) begin
      curPrioNext = hwdata[ICW_CUR_POS +: 8];
      enableNext  = hwdata[ICW_EN_POS];
      arbSelNext  = hwdata[ICW_ARBSEL_POS +: 2];
    end
    if (wrPendReg && addrReg == VBR_OFFSET && !baseLockReg) begin
      vecBaseNext = hwdata;
    end
    if (returnStrobe && !(stateReg == ST_IDLE && returnPriority < pendPrioReg)) begin
      curPrioNext = returnPriority;
    end
    unique case (stateReg)
      ST_IDLE: begin
        if (newReq) begin
          pendPrioNext = PRIO_NONE;
          cntNext      = 2'h0;
          stateNext    = ST_ARB;
        end else if (returnStrobe && returnPriority < pendPrioReg) begin
          foldNext  = 1'b1;
          stateNext = ST_ACK;
        end else if (cpuAccept) begin
          foldNext  = 1'b0;
          stateNext = ST_ACK;
        end
      end
      ST_ARB: begin
        if (newReq) begin
          pendPrioNext = PRIO_NONE;
          cntNext      = 2'h0;
        end else if (cntReg == arbSelReg) begin
          pendPrioNext = winPrio;
          winIdxNext   = winIdx;
          stateNext    = ST_IDLE;
        end else begin
          cntNext = cntReg + 2'h1;
        end
      end
      ST_ACK: begin
        stateNext = foldReg ? ST_PRIO : ST_SAVE;
      end
      ST_SAVE: begin
        stateNext = ST_PRIO;
      end
      ST_PRIO: begin
        enableNext  = 1'b0;
        curPrioNext = pendPrioReg;
        stateNext   = ST_STATUS;
      end
      ST_STATUS: begin
        statusNext  = STATUS_DEFAULT;
        vecAddrNext = ({24'h000000, curPrioReg} << VEC_SHIFT) | vecBaseReg;
        stateNext   = ST_FETCH;
      end
      ST_FETCH: begin
        pendPrioNext = PRIO_NONE;
        cntNext      = 2'h0;
        foldNext     = 1'b0;
        stateNext    = ST_ARB;
      end
      default: begin
        stateNext = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      stateReg    <= ST_IDLE;
      cntReg      <= 2'h0;
      curPrioReg  <= CUR_RESET;
      pendPrioReg <= PRIO_NONE;
      enableReg   <= 1'b0;
      arbSelReg   <= ARBSEL_RESET;
      vecBaseReg  <= VBR_RESET;
      baseLockReg <= 1'b0;
      winIdxReg   <= '0;
      foldReg     <= 1'b0;
      vecAddrReg  <= 32'h0000_0000;
      statusReg   <= 32'h0000_0000;
    end else begin
      stateReg    <= stateNext;
      cntReg      <= cntNext;
      curPrioReg  <= curPrioNext;
      pendPrioReg <= pendPrioNext;
      enableReg   <= enableNext;
      arbSelReg   <= arbSelNext;
      vecBaseReg  <= vecBaseNext;
      baseLockReg <= baseLockNext;
      winIdxReg   <= winIdxNext;
      foldReg     <= foldNext;
      vecAddrReg  <= vecAddrNext;
      statusReg   <= statusNext;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  new_clears_pend_a: assert property (stateReg == ST_IDLE && newReq |=>
    pendPrioReg == 8'h00 && stateReg == ST_ARB)
    else $error("new request did not clear pending priority");
  round_result_a: assert property (stateReg == ST_ARB && !newReq && cntReg == arbSelReg |=>
    pendPrioReg == $past(winPrio) && stateReg == ST_IDLE)
    else $error("round did not store winner");
  request_level_a: assert property (ackStrobe && !foldBranch |->
    $past(pendPrioReg) > $past(curPrioReg))
    else $error("entry taken without higher pending priority");
  accept_gate_a: assert property ($rose(ackStrobe) && !foldBranch |->
    $past(enableReg) && $past(curPrioReg) != 8'hFF && $past(cpuHoldOff) == '0)
    else $error("interrupt taken while blocked");
  ack_clears_a: assert property (ackStrobe |=>
    !pendReg[$past(ackNode)] || $past(hwRequest[ackNode]))
    else $error("winner pending flag not cleared");
  entry_order_a: assert property (ackStrobe && !foldBranch |=>
    ctxSave ##1 !ctxSave ##1 (!enableReg && curPrioReg == pendPrioReg) ##0 statusLoad
    ##1 fetchStrobe) else $error("entry sequence out of order");
  fold_skip_a: assert property (foldBranch |=>
    !ctxSave ##1 statusLoad ##1 fetchStrobe)
    else $error("folded return saved context");
  vector_addr_a: assert property (fetchStrobe |->
    vectorAddr == (({24'h000000, curPrioReg} << 5) | vecBaseReg)
    && statusWord == 32'h0000_1E00) else $error("wrong vector or status word");

endmodule : pia_interrupt_arbiter_unit

// file: design/pia_pkg.sv
// Register map, field positions, reset values and states of the priority interrupt arbiter.
package pia_pkg;

  localparam int          NODE_COUNT      = 8;
  localparam int          HOLD_W          = 6;

  localparam logic [11:0] ICW_OFFSET      = 12'h000;
  localparam logic [11:0] VBR_OFFSET      = 12'h004;
  localparam logic [11:0] NODE_OFFSET     = 12'h040;

  localparam int          ICW_CUR_POS     = 0;
  localparam int          ICW_EN_POS      = 8;
  localparam int          ICW_PEND_POS    = 16;
  localparam int          ICW_ARBSEL_POS  = 24;

  localparam int          NODE_PEND_POS   = 10;
  localparam int          NODE_EN_POS     = 9;
  localparam int          NODE_TYPE_POS   = 8;
  localparam int          NODE_PRIO_POS   = 0;

  localparam logic [7:0]  PRIO_NONE       = 8'h00;
  localparam logic [7:0]  PRIO_MAX        = 8'hFF;
  localparam int          VEC_SHIFT       = 5;

  localparam logic [31:0] VBR_RESET       = 32'h0000_0000;
  localparam logic [7:0]  CUR_RESET       = 8'h00;
  localparam logic [1:0]  ARBSEL_RESET    = 2'h0;

  localparam int          STATUS_PERM_POS = 10;
  localparam int          STATUS_MAP_POS  = 12;
  localparam int          STATUS_STACK_POS = 9;
  localparam logic [6:0]  STATUS_DEPTH_64 = 7'h00;
  localparam logic [31:0] STATUS_DEFAULT  = (32'h0000_0003 << STATUS_PERM_POS)
                                          | (32'h0000_0001 << STATUS_MAP_POS)
                                          | (32'h0000_0001 << STATUS_STACK_POS)
                                          | {25'h0000000, STATUS_DEPTH_64};

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ARB    = 3'b001,
    ST_ACK    = 3'b010,
    ST_SAVE   = 3'b011,
    ST_PRIO   = 3'b100,
    ST_STATUS = 3'b101,
    ST_FETCH  = 3'b110
  } pia_state_t;

endpackage : pia_pkg

// file: design/pia_winner_select.sv
// Combinational search for the highest priority among the competing request nodes.
`timescale 1ns/1ps
module pia_winner_select #(
  parameter int NODES = pia_pkg::NODE_COUNT,
  parameter int IDXW  = 3
) (
  input  wire logic [NODES-1:0] pend,
  input  wire logic [NODES-1:0] enable,
  input  wire logic [NODES-1:0] svcType,
  input  wire logic [7:0]       prio [NODES],
  output logic      [7:0]       winPrio,
  output logic      [IDXW-1:0]  winIdx
);
  import pia_pkg::*;

  always_comb begin
    winPrio = PRIO_NONE;
    winIdx  = '0;
    for (int k = 0; k < NODES; k++) begin
      // Only pending, enabled interrupt-type nodes with a nonzero number compete.
      if (pend[k] && enable[k] && !svcType[k] && prio[k] != PRIO_NONE
          && prio[k] > winPrio) begin
        winPrio = prio[k];
        winIdx  = IDXW'(k);
      end
    end
  end

endmodule : pia_winner_select

// file: tb/pia_cpu_model.sv
// Processor pipeline model that raises hold-off conditions and issues interrupt returns.
`timescale 1ns/1ps
module pia_cpu_model (
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic [pia_pkg::HOLD_W-1:0] holdReq,
  input  wire logic                       retReq,
  input  wire logic [7:0]                 retPrio,
  input  wire logic                       ctxSave,
  input  wire logic                       fetchStrobe,
  output logic      [pia_pkg::HOLD_W-1:0] cpuHoldOff,
  output logic                            returnStrobe,
  output logic      [7:0]                 returnPriority
);
  import pia_pkg::*;
  logic entry_reg;
  // The entry bit stays high from the context save up to the first fetch.
  always_ff @(posedge clock) begin
    if (rst) begin
      entry_reg <= 1'b0;
      cpuHoldOff <= '0;
      returnStrobe <= 1'b0;
      returnPriority <= 8'h00;
    end else begin
      if (ctxSave) begin
        entry_reg <= 1'b1;
      end else if (fetchStrobe) begin
        entry_reg <= 1'b0;
      end
      cpuHoldOff <= holdReq | HOLD_W'(entry_reg);
      returnStrobe <= retReq;
      returnPriority <= retReq ? retPrio : ~returnPriority;
    end
  end
endmodule : pia_cpu_model

// file: tb/pia_interrupt_arbiter_unit_tb.sv
// Self-checking testbench of the interrupt arbiter unit.
`timescale 1ns/1ps
module pia_interrupt_arbiter_unit_tb;
  import pia_pkg::*;
  logic        clock, rst, hsel, hwrite, hreadyout, hresp, retReq, returnStrobe, intRequest;
  logic        cpuAccept, ackStrobe, foldBranch, ctxSave, statusLoad, fetchStrobe, globalEnable;
  logic [1:0]  htrans;
  logic [2:0]  hsize, ackNode;
  logic [5:0]  cpuHoldOff, holdReq;
  logic [7:0]  hwRequest, retPrio, returnPriority, curPriority, pendPriority, pb, pr [8];
  logic [31:0] haddr, hwdata, hrdata, statusWord, vectorAddr, vb;
  logic [1:0]  sel;
  logic        rdPhase = 1'b0;
  logic        slPrev = 1'b0;
  logic        rdyN = 1'b1;
  logic [31:0] rdQ [$], vecQ [$], ackQ [$];
  int          n_errors = 0, check_count = 0, nAcc = 0, nCtx = 0, nFetch = 0, c0;

  pia_interrupt_arbiter_unit #(.NODES(8)) DUT (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .hwRequest(hwRequest), .cpuHoldOff(cpuHoldOff),
    .returnStrobe(returnStrobe), .returnPriority(returnPriority), .intRequest(intRequest),
    .cpuAccept(cpuAccept), .ackStrobe(ackStrobe), .ackNode(ackNode), .foldBranch(foldBranch),
    .ctxSave(ctxSave), .statusLoad(statusLoad), .statusWord(statusWord),
    .fetchStrobe(fetchStrobe), .vectorAddr(vectorAddr), .curPriority(curPriority),
    .pendPriority(pendPriority), .globalEnable(globalEnable));

  pia_cpu_model CPU (
    .clock(clock), .rst(rst), .holdReq(holdReq), .retReq(retReq), .retPrio(retPrio),
    .ctxSave(ctxSave), .fetchStrobe(fetchStrobe), .cpuHoldOff(cpuHoldOff),
    .returnStrobe(returnStrobe), .returnPriority(returnPriority));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= a;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (rdyN === 1'b1) break;
    end
    if (n >= 40) begin
      n_errors++;
      complete_run();
    end
    hsel <= 1'b0;
    htrans <= 2'b00;
    if (wr) hwdata <= d;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (rdyN === 1'b1) break;
    end
    if (n >= 40) begin
      n_errors++;
      complete_run();
    end
  endtask : bus

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rdQ.push_back(e);
    bus(1'b0, 32'(a), 32'h0);
  endtask : rd

  task automatic waitPend();
    int n;
    for (n = 0; n < 40 && pendPriority !== 8'h00; n++) @(posedge clock);
    for (n = 0; n < 40 && pendPriority === 8'h00; n++) @(posedge clock);
    if (n >= 40) begin
      n_errors++;
      complete_run();
    end
    tick(1);
  endtask : waitPend

  task automatic waitFetch();
    int n;
    int f0;
    f0 = nFetch;
    for (n = 0; n < 60 && nFetch == f0; n++) @(posedge clock);
    if (n >= 60) begin
      n_errors++;
      complete_run();
    end
    tick(1);
  endtask : waitFetch

  task automatic expectEntry(input int k, input logic fold);
    ackQ.push_back(32'(k) | (32'(fold) << 3));
    vecQ.push_back(vb | (32'(pr[k]) << VEC_SHIFT));
  endtask : expectEntry

  function automatic logic [31:0] icw(logic [7:0] c, logic e, logic [7:0] p);
    return {6'h00, sel, p, 7'h00, e, c};
  endfunction : icw

  function automatic logic [31:0] nw(logic p, logic e, logic t, logic [7:0] q);
    return {21'h000000, p, e, t, q};
  endfunction : nw

  always @(negedge clock) rdyN = hreadyout;

  always @(posedge clock) begin
    if (rdPhase && hreadyout === 1'b1) begin
      cmp("hrdata", rdQ.size() ? rdQ.pop_front() : 32'hXXXXXXXX, hrdata);
      cmp("hresp", 32'h0, 32'(hresp));
    end
    if (fetchStrobe === 1'b1) begin
      cmp("vectorAddr", vecQ.size() ? vecQ.pop_front() : 32'hXXXXXXXX, vectorAddr);
      cmp("statusWord", STATUS_DEFAULT, statusWord);
      cmp("statusLoad", 32'h1, 32'(slPrev));
      nFetch <= nFetch + 1;
    end
    if (ackStrobe === 1'b1) begin
      cmp("ack", ackQ.size() ? ackQ.pop_front() : 32'hX, 32'({foldBranch, ackNode}));
    end
    slPrev <= statusLoad;
    if (cpuAccept === 1'b1) nAcc <= nAcc + 1;
    if (ctxSave === 1'b1) nCtx <= nCtx + 1;
    if (hreadyout) rdPhase <= hsel & htrans[1] & ~hwrite;
  end

  initial begin
    {hsel, hwrite, retReq, rst} = 4'h1;
    {htrans, haddr, hwdata, hwRequest, holdReq, retPrio} = '0;
    hsize = 3'h2;
    void'($urandom(32'h681adc90));
    vb = ($urandom & 32'h0007_FFFF) << 13;
    pb = 8'h10 + 8'($urandom % 32'h80);
    sel = 2'($urandom);
    for (int k = 0; k < 8; k++) pr[k] = (k == 0) ? 8'h00 : (k == 2) ? pb + 8'h20 : pb + 8'(k);
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(ICW_OFFSET, 32'h0);
    rd(VBR_OFFSET, VBR_RESET);
    rd(12'h020, 32'h0);
    bus(1'b1, 32'(VBR_OFFSET), vb);
    rd(VBR_OFFSET, vb);
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, 32'(NODE_OFFSET) + 32'(4 * k), nw(0, k != 6, k == 2, pr[k]));
    end
    hwRequest <= 8'h6D;
    tick(1);
    hwRequest <= 8'h00;
    waitPend();
    cmp("pendPriority", 32'(pr[5]), 32'(pendPriority));
    cmp("intRequest", 32'h1, 32'(intRequest));
    cmp("acceptCount", 32'h0, 32'(nAcc));
    rd(NODE_OFFSET + 12'h008, nw(1, 1, 1, pr[2]));
    bus(1'b1, 32'(ICW_OFFSET), icw(pr[5], 1, 8'hFF));
    tick(2);
    cmp("intRequest", 32'h0, 32'(intRequest));
    rd(ICW_OFFSET, icw(pr[5], 1, pr[5]));
    holdReq <= 6'h01;
    bus(1'b1, 32'(ICW_OFFSET), icw(8'h00, 1, 8'h00));
    for (int i = 0; i < 6; i++) begin
      holdReq <= 6'(1 << i);
      tick(4);
      cmp("acceptCount", 32'h0, 32'(nAcc));
    end
    expectEntry(5, 1'b0);
    holdReq <= 6'h00;
    waitFetch();
    cmp("curPriority", 32'(pr[5]), 32'(curPriority));
    cmp("globalEnable", 32'h0, 32'(globalEnable));
    waitPend();
    cmp("pendPriority", 32'(pr[3]), 32'(pendPriority));
    cmp("intRequest", 32'h0, 32'(intRequest));
    rd(NODE_OFFSET + 12'h014, nw(0, 1, 0, pr[5]));
    bus(1'b1, 32'(VBR_OFFSET), 32'h0000_4000);
    rd(VBR_OFFSET, vb);
    c0 = nCtx;
    expectEntry(3, 1'b1);
    retPrio <= pr[3] - 8'h01;
    retReq <= 1'b1;
    tick(1);
    retReq <= 1'b0;
    waitFetch();
    cmp("ctxSaveCount", 32'(c0), 32'(nCtx));
    cmp("curPriority", 32'(pr[3]), 32'(curPriority));
    tick(10);
    cmp("pendPriority", 32'h0, 32'(pendPriority));
    retPrio <= 8'hFE;
    retReq <= 1'b1;
    tick(1);
    retReq <= 1'b0;
    tick(4);
    cmp("curPriority", 32'h0000_00FE, 32'(curPriority));
    bus(1'b1, 32'(NODE_OFFSET) + 32'h10, nw(1, 1, 0, pr[4]));
    waitPend();
    cmp("pendPriority", 32'(pr[4]), 32'(pendPriority));
    cmp("intRequest", 32'h0, 32'(intRequest));
    expectEntry(4, 1'b0);
    bus(1'b1, 32'(ICW_OFFSET), icw(pr[4] - 8'h01, 1, 8'h00));
    waitFetch();
    cmp("curPriority", 32'(pr[4]), 32'(curPriority));
    complete_run();
  end
endmodule : pia_interrupt_arbiter_unit_tb
